// File: vrefc_addr_capture.sv
// Captures an AHB-Lite address phase for use in the following data phase
`timescale 1ns/100ps
module vrefc_addr_capture (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Address phase
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  // Captured data-phase controls
  output logic wr_word_reg,
  output logic wr_low_lane_reg
);

  logic take;
  logic hit_word;
  logic low_lane;

  // Only a word-register hit can change state; the high view is read only
  assign take = hsel & hready & (htrans == vrefc_pkg::HTRANS_NONSEQ) & hwrite;
  assign hit_word = (haddr & vrefc_pkg::ADDR_DECODE_MASK) == vrefc_pkg::ADDR_CTL_WORD;
  assign low_lane = !((hsize == vrefc_pkg::HSIZE_BYTE) && haddr[0]);

  // Hold write intent for one data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_word_reg <= 1'b0;
      wr_low_lane_reg <= 1'b0;
    end
    else if (hready)
    begin
      wr_word_reg <= take & hit_word;
      wr_low_lane_reg <= take & hit_word & low_lane;
    end
  end

endmodule

// File: vrefc_checker.sv
// Concurrent checks on the ports of the voltage reference control block
`timescale 1ns/100ps
module vrefc_checker (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus address phase and read data
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // Requests and drive lines
  input wire vrefc_pkg::vrefc_req_t module_req [vrefc_pkg::NUM_MODULES],
  input wire vrefc_pkg::vrefc_drive_t drive
);
  logic [3:0] now_st;
  logic [3:0] st_q;
  logic mode_ok;
  logic rd_take;
  logic wr_dph;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // ----------------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------------
  // Combined status {mode, busy, bandgap, generator}; idle modules get no mode vote
  always_comb
  begin
    now_st = 4'h0;
    mode_ok = 1'b1;
    for (int i = 0; i < vrefc_pkg::NUM_MODULES; i++)
    begin
      now_st[0] = now_st[0] | module_req[i].generator_request;
      now_st[1] = now_st[1] | module_req[i].bandgap_request;
      now_st[2] = now_st[2] | module_req[i].conversion_active;
      if (module_req[i].generator_request | module_req[i].bandgap_request)
        mode_ok = mode_ok & module_req[i].sampled_mode_request;
    end
    now_st[3] = mode_ok & (now_st[0] | now_st[1]);
  end

  assign rd_take = hsel && hready && (htrans == vrefc_pkg::HTRANS_NONSEQ) && !hwrite;

  // Status as the block should have registered it, and the write data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_q <= 4'h0;
      wr_dph <= 1'b0;
    end
    else
    begin
      st_q <= now_st;
      wr_dph <= hsel && hready && (htrans == vrefc_pkg::HTRANS_NONSEQ) && hwrite;
    end
  end

  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  sequence s_busy_held;
    now_st[2] [*3];
  endsequence
  sequence s_word_read;
    rd_take && (haddr[7:2] == 6'h00);
  endsequence
  property p_busy_block;
    (s_busy_held ##0 wr_dph) |=> $stable(drive.temp_sensor_enable) && $stable(drive.level);
  endproperty
  property p_gen_or;
    now_st[0] |=> drive.generator_enable;
  endproperty
  property p_gen_off;
    $fell(drive.generator_enable) |-> !$past(now_st[0]);
  endproperty
  property p_reserved;
    s_word_read |=> (hrdata[31:12] == 20'h00000) && (hrdata[7:6] == 2'h0) && (hrdata[2:1] == 2'h0);
  endproperty
  property p_status;
    s_word_read |=> hrdata[11:8] == $past(st_q);
  endproperty
  property p_high;
    (rd_take && (haddr[7:2] == 6'h01)) |=> hrdata == {28'h0000000, $past(st_q)};
  endproperty
  property p_level;
    s_word_read |=> drive.level == (hrdata[5] ? vrefc_pkg::LEVEL_2V5 :
      (hrdata[4] ? vrefc_pkg::LEVEL_2V0 : vrefc_pkg::LEVEL_1V5));
  endproperty
  property p_tsens;
    s_word_read |=> drive.temp_sensor_enable == !hrdata[3];
  endproperty

  a_busy_block: assert property (p_busy_block) else $error("write changed fields while busy");
  a_gen_or: assert property (p_gen_or) else $error("generator not enabled on request");
  a_gen_off: assert property (p_gen_off) else $error("generator dropped with request pending");
  a_reserved: assert property (p_reserved) else $error("reserved bits read nonzero");
  a_status: assert property (p_status) else $error("status bits wrong");
  a_high: assert property (p_high) else $error("high byte view wrong");
  a_level: assert property (p_level) else $error("level drive disagrees with select");
  a_tsens: assert property (p_tsens) else $error("sensor enable disagrees with control");
endmodule

// File: vrefc_periph_model.sv
// Behavioural model of the peripheral modules that ask for reference voltages
`timescale 1ns/100ps
module vrefc_periph_model (
  // Clock
  input wire logic hclk,
  // Request pattern wanted by the bench
  input wire vrefc_pkg::vrefc_req_t want [vrefc_pkg::NUM_MODULES],
  // Requests toward the reference block
  output vrefc_pkg::vrefc_req_t module_req [vrefc_pkg::NUM_MODULES]
);
  // Requests move only after a clock edge, as real module logic would
  always_ff @(posedge hclk)
    module_req <= want;
endmodule

// File: vrefc_pkg.sv
// Package for the voltage reference control block: map, fields, carriers
package vrefc_pkg;

  // ----------------------------------------------------------------------
  // Register map (index form: byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [1:0] IDX_CTL_WORD = 2'h0;    // reference_control_word and its low byte view
  localparam logic [1:0] IDX_CTL_HIGH = 2'h1;    // reference_control_high_byte view
  localparam logic [31:0] ADDR_CTL_WORD = {30'h0, IDX_CTL_WORD} << 2;
  localparam logic [31:0] ADDR_CTL_HIGH = {30'h0, IDX_CTL_HIGH} << 2;
  localparam logic [31:0] ADDR_DECODE_MASK = 32'h0000_00FC;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int BIT_REF_ENABLE = 0;
  localparam int BIT_TEMP_OFF = 3;
  localparam int BIT_LEVEL_LO = 4;
  localparam int BIT_LEVEL_HI = 5;
  localparam int BIT_GEN_ACTIVE = 8;
  localparam int BIT_BG_ACTIVE = 9;
  localparam int BIT_GEN_BUSY = 10;
  localparam int BIT_SAMPLED = 11;
  localparam logic [15:0] CTL_RESET_VALUE = 16'h0080;
  localparam logic [15:0] CTL_READ_MASK = 16'h0F39;   // Reserved 15:12, 7:6, 2:1 read zero
  localparam logic [7:0] LOW_BYTE_RESET = 8'h80;
  localparam logic [7:0] HIGH_BYTE_RESET = 8'h00;

  // ----------------------------------------------------------------------
  // Bus constants and requester count
  // ----------------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_BYTE = 3'h0;
  localparam logic [31:0] HRDATA_RESET = 32'h0000_0000;
  localparam int NUM_MODULES = 2;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  // Per-module request bundle
  typedef struct packed {
    logic generator_request;
    logic bandgap_request;
    logic sampled_mode_request;
    logic conversion_active;
  } vrefc_req_t;

  // Combined requests
  typedef struct packed {
    logic any_gen;
    logic any_bg;
    logic sampled;
    logic busy;
  } vrefc_sum_t;

  // Writable fields of the control word
  typedef struct packed {
    logic [1:0] level_select_field;
    logic temp_sensor_off;
    logic reference_enable_bit;
  } vrefc_ctl_t;

  // Output level choices
  typedef enum logic [1:0] {
    LEVEL_1V5,
    LEVEL_2V0,
    LEVEL_2V5
  } vrefc_level_t;

  // Drive lines to the analog side
  typedef struct packed {
    logic generator_enable;
    logic bandgap_enable;
    logic bandgap_sampled;
    logic temp_sensor_enable;
    vrefc_level_t level;
  } vrefc_drive_t;

  // Assemble the 16-bit view from writable fields and live status
  function automatic logic [15:0] vrefc_pack_word(input vrefc_ctl_t c, input vrefc_sum_t s);
    logic [15:0] w;
    w = 16'h0000;
    w[BIT_REF_ENABLE] = c.reference_enable_bit;
    w[BIT_TEMP_OFF] = c.temp_sensor_off;
    w[BIT_LEVEL_HI:BIT_LEVEL_LO] = c.level_select_field;
    w[BIT_GEN_ACTIVE] = s.any_gen;
    w[BIT_BG_ACTIVE] = s.any_bg;
    w[BIT_GEN_BUSY] = s.busy;
    w[BIT_SAMPLED] = s.sampled;
    return w & CTL_READ_MASK;
  endfunction

  // Decode the two-bit level code
  function automatic vrefc_level_t vrefc_decode_level(input logic [1:0] code);
    vrefc_level_t l;
    l = LEVEL_2V5;
    if (code == 2'h0)
      l = LEVEL_1V5;
    else if (code == 2'h1)
      l = LEVEL_2V0;
    return l;
  endfunction

endpackage

// File: vrefc_req_combine.sv
// Combines per-module reference requests into the shared request lines
`timescale 1ns/100ps
module vrefc_req_combine (
  // Requests from modules
  input wire vrefc_pkg::vrefc_req_t req [vrefc_pkg::NUM_MODULES],
  // Combined view
  output vrefc_pkg::vrefc_sum_t sum
);

  // ----------------------------------------------------------------------
  // OR of enable requests, AND of mode requests
  // ----------------------------------------------------------------------
  // A module with no active request does not vote on the mode
  always_comb
  begin
    logic any_req;
    logic all_sampled;
    any_req = 1'b0;
    all_sampled = 1'b1;
    sum = '0;
    for (int i = 0; i < vrefc_pkg::NUM_MODULES; i++)
    begin
      sum.any_gen = sum.any_gen | req[i].generator_request;
      sum.any_bg = sum.any_bg | req[i].bandgap_request;
      sum.busy = sum.busy | req[i].conversion_active;
      if (req[i].generator_request || req[i].bandgap_request)
      begin
        any_req = 1'b1;
        all_sampled = all_sampled & req[i].sampled_mode_request;
      end
    end
    sum.sampled = any_req & all_sampled;  // Static wins when nobody asks
  end

endmodule

// File: vrefc_tb.sv
// Self-checking bench for the voltage reference control block
`timescale 1ns/100ps
module testbench;
  localparam logic [31:0] adr_w = vrefc_pkg::ADDR_CTL_WORD;
  localparam logic [31:0] adr_h = vrefc_pkg::ADDR_CTL_HIGH;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h00000000;
  logic [31:0] hrdata;
  logic hresp;
  wire hready;
  vrefc_pkg::vrefc_req_t want [vrefc_pkg::NUM_MODULES] = '{default: 4'h0};
  vrefc_pkg::vrefc_req_t module_req [vrefc_pkg::NUM_MODULES];
  vrefc_pkg::vrefc_drive_t drive;
  logic [15:0] ctl_m = 16'h0000;
  logic [31:0] exp_q [$];
  logic [31:0] exp_v;
  logic rd_dph = 1'b0;
  int fails = 0;
  int n_compared = 0;

  vrefc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .module_req(module_req), .drive(drive));
  vrefc_periph_model peers (.hclk(hclk), .want(want), .module_req(module_req));

  // ----------------------------------------------------------------------
  // Clock, reference model and bus tasks
  // ----------------------------------------------------------------------
  initial
    forever #5 hclk = ~hclk;

  // Expected status {mode, busy, bandgap, generator}
  function automatic logic [3:0] stat();
    logic [3:0] s;
    logic ok;
    s = 4'h0;
    ok = 1'b1;
    foreach (want[i])
    begin
      s = s | {1'b0, want[i].conversion_active, want[i].bandgap_request, want[i].generator_request};
      if (want[i].generator_request | want[i].bandgap_request)
        ok = ok & want[i].sampled_mode_request;
    end
    s[3] = ok & (s[0] | s[1]);
    return s;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One single transfer; no wait count is assumed, the watchdog ends a hang
  task automatic bus(input logic [31:0] a, input logic wr, input logic [2:0] sz, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= vrefc_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= sz;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(a, 1'b0, 3'h2, 32'h00000000);
  endtask

  // Busy is judged before the transfer, since the block looks at it one cycle back
  task automatic wr(input logic [31:0] a, input logic [2:0] sz, input logic [31:0] d, input logic upd);
    logic [3:0] s;
    s = stat();
    bus(a, 1'b1, sz, d);
    if (upd && !s[2])
      ctl_m = d[15:0] & 16'h0039;
  endtask

  task automatic setreq(input logic [31:0] v);
    foreach (want[i])
      want[i] <= vrefc_pkg::vrefc_req_t'(v[4*i +: 4]);
    repeat (4) @(posedge hclk);
  endtask

  // Drive lines are looked at mid-cycle, once the storing edge has settled
  task automatic chk_drive();
    logic [3:0] s;
    vrefc_pkg::vrefc_level_t lv;
    s = stat();
    lv = ctl_m[5] ? vrefc_pkg::LEVEL_2V5 : (ctl_m[4] ? vrefc_pkg::LEVEL_2V0 : vrefc_pkg::LEVEL_1V5);
    @(negedge hclk);
    chk(32'(drive), 32'({ctl_m[0] | s[0], ctl_m[0] | s[0] | s[1], s[3], !ctl_m[3], lv}));
    @(posedge hclk);
  endtask

  // Read data is compared at the edge that ends each read data phase
  always @(posedge hclk)
  begin
    if (rd_dph)
    begin
      exp_v = exp_q.pop_front();
      chk(hrdata, exp_v);
      chk({31'h00000000, hresp}, 32'h00000000);
    end
    rd_dph <= hresetn && hsel && hready && (htrans == vrefc_pkg::HTRANS_NONSEQ) && !hwrite;
  end

  task automatic report_and_stop();
    if (fails == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h4707));
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(adr_w, 32'h00000000);
    chk_drive();
    // Every level code, with random junk in reserved and status bits
    for (int c = 0; c < 4; c++)
    begin
      wr(adr_w, 3'h2, ($urandom() & 32'hFFFFFFCF) | (32'(c) << 4), 1'b1);
      chk_drive();
      rd(adr_w, {24'h000000, ctl_m[7:0]});
    end
    wr(adr_w, 3'h0, 32'h00000011, 1'b1);
    wr(32'h00000001, 3'h0, 32'h00003900, 1'b0);
    wr(adr_h, 3'h2, 32'h0000FF3F, 1'b0);
    rd(adr_w, {24'h000000, ctl_m[7:0]});
    rd(32'h00000008, 32'h00000000);
    // Random request mixes, with writes that busy may block
    for (int k = 0; k < 32; k++)
    begin
      setreq($urandom());
      wr(adr_w, 3'h2, $urandom(), 1'b1);
      chk_drive();
      rd(adr_w, {20'h00000, stat(), ctl_m[7:0]});
      rd(adr_h, {28'h0000000, stat()});
    end
    // Reset in mid-run: fields clear and drive lines fall back to their idle values
    setreq(32'h00000000);
    hresetn <= 1'b0;
    ctl_m = 16'h0000;
    chk_drive();
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(adr_w, 32'h00000000);
    chk_drive();
    repeat (2) @(posedge hclk);
    report_and_stop();
  end

  // Whole run needs well under 1000 cycles
  initial
  begin
    repeat (5000) @(posedge hclk);
    fails++;
    report_and_stop();
  end
endmodule

bind vrefc_top vrefc_checker u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .module_req(module_req),
  .drive(drive));

// File: vrefc_top.sv
// Voltage reference control register with AHB-Lite access and request combining
`timescale 1ns/100ps

module vrefc_top (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Module requests
  input wire vrefc_pkg::vrefc_req_t module_req [vrefc_pkg::NUM_MODULES],
  // Analog drive lines
  output vrefc_pkg::vrefc_drive_t drive
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  vrefc_pkg::vrefc_sum_t sum_now;
  vrefc_pkg::vrefc_sum_t status_reg;
  vrefc_pkg::vrefc_ctl_t ctl_reg;
  vrefc_pkg::vrefc_ctl_t ctl_next;
  vrefc_pkg::vrefc_drive_t drive_reg;
  vrefc_pkg::vrefc_drive_t drive_next;
  logic wr_word_reg;
  logic wr_low_lane_reg;
  logic write_ok;
  logic read_take;
  logic [31:0] read_addr;
  logic [15:0] word_view;
  logic [31:0] hrdata_reg;
  logic [31:0] hrdata_next;
  logic hreadyout_reg;
  logic hresp_reg;

  // ----------------------------------------------------------------------
  // Request combining
  // ----------------------------------------------------------------------
  vrefc_req_combine u_combine (
    .req (module_req),
    .sum (sum_now)
  );

  // Status is sampled once so the read view and the busy check agree
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      status_reg <= '0;
    else
      status_reg <= sum_now;
  end

  // ----------------------------------------------------------------------
  // Bus address phase capture
  // ----------------------------------------------------------------------
  vrefc_addr_capture u_capture (
    .hclk (hclk),
    .hresetn (hresetn),
    .hsel (hsel),
    .haddr (haddr),
    .htrans (htrans),
    .hwrite (hwrite),
    .hsize (hsize),
    .hready (hready),
    .wr_word_reg (wr_word_reg),
    .wr_low_lane_reg (wr_low_lane_reg)
  );

  // ----------------------------------------------------------------------
  // Writable fields
  // ----------------------------------------------------------------------
  // Busy is judged in the data phase, the moment the value would land
  assign write_ok = wr_word_reg & wr_low_lane_reg & !status_reg.busy;

  // Only the low lane carries writable bits; the high lane is status and reserved bits
  always_comb
  begin
    ctl_next = ctl_reg;
    if (write_ok)
    begin
      ctl_next.reference_enable_bit = hwdata[vrefc_pkg::BIT_REF_ENABLE];
      ctl_next.temp_sensor_off = hwdata[vrefc_pkg::BIT_TEMP_OFF];
      ctl_next.level_select_field = hwdata[vrefc_pkg::BIT_LEVEL_HI:vrefc_pkg::BIT_LEVEL_LO];
    end
  end

  // Reserved and status positions are never stored
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctl_reg.reference_enable_bit <= vrefc_pkg::CTL_RESET_VALUE[vrefc_pkg::BIT_REF_ENABLE];
      ctl_reg.temp_sensor_off <= vrefc_pkg::CTL_RESET_VALUE[vrefc_pkg::BIT_TEMP_OFF];
      ctl_reg.level_select_field <= vrefc_pkg::CTL_RESET_VALUE[vrefc_pkg::BIT_LEVEL_HI:vrefc_pkg::BIT_LEVEL_LO];
    end
    else
      ctl_reg <= ctl_next;
  end

  // ----------------------------------------------------------------------
  // Drive lines to the analog side
  // ----------------------------------------------------------------------
  // Enable bit keeps the reference on; requests keep it on after clearing
  always_comb
  begin
    drive_next.generator_enable = ctl_next.reference_enable_bit | sum_now.any_gen;
    drive_next.bandgap_enable = ctl_next.reference_enable_bit | sum_now.any_gen | sum_now.any_bg;
    drive_next.bandgap_sampled = sum_now.sampled;
    drive_next.temp_sensor_enable = !ctl_next.temp_sensor_off;
    drive_next.level = vrefc_pkg::vrefc_decode_level(ctl_next.level_select_field);
  end

  // Registered so the analog side never sees decode glitches
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      drive_reg.generator_enable <= 1'b0;
      drive_reg.bandgap_enable <= 1'b0;
      drive_reg.bandgap_sampled <= 1'b0;
      drive_reg.temp_sensor_enable <= 1'b1;
      drive_reg.level <= vrefc_pkg::LEVEL_1V5;
    end
    else
      drive_reg <= drive_next;
  end

  assign drive = drive_reg;

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  assign read_take = hsel & hready & (htrans == vrefc_pkg::HTRANS_NONSEQ) & !hwrite;
  assign read_addr = haddr & vrefc_pkg::ADDR_DECODE_MASK;

  // Forward a write landing now so a back-to-back read sees it
  assign word_view = vrefc_pkg::vrefc_pack_word(ctl_next, status_reg);

  // Word view on index 0, high byte alone on index 1, zero elsewhere
  always_comb
  begin
    hrdata_next = hrdata_reg;
    if (read_take)
    begin
      if (read_addr == vrefc_pkg::ADDR_CTL_WORD)
        hrdata_next = {16'h0000, word_view};
      else if (read_addr == vrefc_pkg::ADDR_CTL_HIGH)
        hrdata_next = {24'h000000, word_view[15:8]};
      else
        hrdata_next = vrefc_pkg::HRDATA_RESET;
    end
  end

  // Read data held in a flop for the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_reg <= vrefc_pkg::HRDATA_RESET;
    else
      hrdata_reg <= hrdata_next;
  end

  // ----------------------------------------------------------------------
  // Bus response
  // ----------------------------------------------------------------------
  // Zero wait states; every access, mapped or not, answers OKAY
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout_reg <= 1'b1;
      hresp_reg <= 1'b0;
    end
    else
    begin
      hreadyout_reg <= 1'b1;
      hresp_reg <= 1'b0;
    end
  end

  assign hrdata = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp = hresp_reg;

endmodule
